// ### include/bcr_pkg.sv
// shared constants and types for the bi-level coder host register bank
package bcr_pkg;
  localparam logic [3:0] ADDR_SYSCFG = 4'h0;
  localparam logic [3:0] ADDR_PARAM = 4'h1;
  localparam logic [3:0] ADDR_CMDSTAT = 4'h2;
  localparam logic [3:0] ADDR_INTEN = 4'h3;
  localparam logic [3:0] ADDR_PIXLO = 4'h4;
  localparam logic [3:0] ADDR_PIXHI = 4'h5;
  localparam logic [3:0] ADDR_LINLO = 4'h6;
  localparam logic [3:0] ADDR_LINHI = 4'h7;
  localparam logic [3:0] ADDR_DONELO = 4'h8;
  localparam logic [3:0] ADDR_DONEHI = 4'h9;
  localparam logic [3:0] ADDR_CTXBUF = 4'hA;
  localparam logic [3:0] ADDR_OPMODE = 4'hB;
  localparam logic [3:0] ADDR_MARKER = 4'hC;
  localparam logic [3:0] ADDR_SCALE = 4'hD;
  // system configuration fields
  localparam int SYS_RST = 0;
  localparam int SYS_CBW_LO = 1;
  localparam int SYS_CBSWB = 3;
  localparam int SYS_CBSW = 4;
  localparam int SYS_BYSW = 5;
  localparam int SYS_PAR = 6;
  localparam int SYS_PB16 = 7;
  // parameter fields
  localparam int PAR_TWOLINE = 5;
  // command fields
  localparam int CMD_INIT = 0;
  localparam int CMD_RUN = 1;
  localparam int CMD_CTXLS = 2;
  localparam int CMD_PAUSE = 3;
  // status fields
  localparam int ST_DONE = 0;
  localparam int ST_DREADY = 1;
  localparam int ST_MARK = 2;
  localparam int ST_IRQ = 3;
  localparam int ST_OVF = 4;
  localparam int ST_PAUSED = 5;
  // operation mode fields
  localparam int OPM_MODE_LO = 0;
  localparam int OPM_SKIP_LO = 2;
  localparam int OPM_TP = 4;
  localparam int OPM_NOLMINIT = 5;
  localparam logic [1:0] MODE_ENC = 2'h0;
  localparam logic [1:0] MODE_DEC = 2'h1;
  localparam logic [1:0] MODE_THRU = 2'h2;
  localparam logic [1:0] MODE_LMLS = 2'h3;
  // scaling fields
  localparam int SCL_DOWN = 0;
  localparam int SCL_UP = 1;
  // reset values and limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] MARK_SDNORM = 8'h02;
  localparam logic [15:0] MAX_PIX_TWOLINE = 16'h2800;
  localparam int CTX_DEPTH = 1024;
  localparam int CTX_AW = 10;
  localparam logic [9:0] CTX_LAST = 10'h3FF;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_INIT = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HOLD = 4'b1000
  } bcr_state_t;
  // engine side event bundle
  typedef struct packed {
    logic lineDone;
    logic wordReady;
    logic markerSeen;
    logic [7:0] markerCode;
    logic counterOverflow;
  } bcr_engine_t;
endpackage

// ### tb/bcr_host_model.sv
// host processor model driving the register bus of the coder
`timescale 1ns/1ns
module bcr_host_model (
  // clock
  input wire logic clock,
  // host bus
  output logic chipSelN,
  output logic [3:0] registerAddressLines,
  output logic writeStrobeN,
  output logic readStrobeN,
  output logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOeN
);
  int extra = 0;
  initial begin
    chipSelN = 1'b1;
    registerAddressLines = 4'h0;
    writeStrobeN = 1'b1;
    readStrobeN = 1'b1;
    hostDataIn = 8'h00;
  end
  // one write, strobe high again for a cycle before the next access
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    chipSelN <= 1'b0;
    registerAddressLines <= a;
    writeStrobeN <= 1'b0;
    hostDataIn <= d;
    repeat (1 + extra) @(posedge clock);
    chipSelN <= 1'b1;
    writeStrobeN <= 1'b1;
    hostDataIn <= ~d;
  endtask
  // one read, data taken once the address has stood 2 + extra cycles
  task automatic rd(input logic [3:0] a, output logic [7:0] d,
                    output logic oe);
    @(posedge clock);
    chipSelN <= 1'b0;
    registerAddressLines <= a;
    readStrobeN <= 1'b0;
    repeat (2 + extra) @(posedge clock);
    #1;
    d = hostDataOut;
    oe = hostDataOeN;
    @(posedge clock);
    chipSelN <= 1'b1;
    readStrobeN <= 1'b1;
  endtask
  task automatic softReset();
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h00);
  endtask
endmodule

// ### tb/bcr_host_regs_bench.sv
// self-checking bench for the coder host register bank
`timescale 1ns/1ns
module bcr_host_regs_bench;
  import bcr_pkg::*;
  logic clock, rstn, chipSelN, writeStrobeN, readStrobeN;
  logic hostDataOeN, interruptRequestOut, engineRun, pauseMode;
  logic [3:0] registerAddressLines;
  logic [7:0] hostDataIn, hostDataOut, sysConfig, templateParams;
  logic [7:0] opMode, scaleCtrl, markerCodeOut;
  logic [15:0] pixelsPerLine, lineTarget;
  bcr_engine_t engineEvents;
  int n_errors = 0;
  int compares = 0;
  logic [7:0] mdl [16];
  logic [31:0] seed = 32'h00015DA3;
  logic [3:0] rwA [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                          4'hB, 4'hD};

  bcr_host_regs DUT (.clock(clock), .rstn(rstn), .chipSelN(chipSelN),
    .registerAddressLines(registerAddressLines),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOeN(hostDataOeN), .interruptRequestOut(interruptRequestOut),
    .engineEvents(engineEvents), .sysConfig(sysConfig),
    .templateParams(templateParams), .opMode(opMode),
    .scaleCtrl(scaleCtrl), .markerCodeOut(markerCodeOut),
    .pixelsPerLine(pixelsPerLine), .lineTarget(lineTarget),
    .engineRun(engineRun), .pauseMode(pauseMode));

  bcr_host_model HOST (.clock(clock), .chipSelN(chipSelN),
    .registerAddressLines(registerAddressLines),
    .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
    .hostDataIn(hostDataIn), .hostDataOut(hostDataOut),
    .hostDataOeN(hostDataOeN));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic rnd(output logic [7:0] v);
    seed = xs(seed);
    v = seed[7:0];
  endtask

  task automatic results();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    HOST.rd(a, d, oe);
    chk({8'h00, d}, {8'h00, exp}, "read data");
    chk({15'h0000, oe}, 16'h0000, "data enable");
  endtask

  task automatic statBit(input int b, input logic exp);
    logic [7:0] d;
    logic oe;
    HOST.rd(ADDR_CMDSTAT, d, oe);
    chk({15'h0000, d[b]}, {15'h0000, exp}, "status bit");
  endtask

  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic pulse(input int which, input logic [7:0] code);
    @(posedge clock);
    engineEvents.markerCode <= code;
    if (which == 0) engineEvents.lineDone <= 1'b1;
    if (which == 1) engineEvents.markerSeen <= 1'b1;
    if (which == 2) engineEvents.counterOverflow <= 1'b1;
    @(posedge clock);
    engineEvents.lineDone <= 1'b0;
    engineEvents.markerSeen <= 1'b0;
    engineEvents.counterOverflow <= 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    results();
  end

  initial begin
    logic [7:0] v, d;
    logic [3:0] a;
    logic oe;
    logic [7:0] q [$];
    int k;
    rstn <= 1'b0;
    engineEvents <= '0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 16; i++) begin
      mdl[i] = 8'h00;
      if (i != 2 && i != 10 && i != 12) rdChk(4'(i), 8'h00);
    end
    for (int i = 0; i < 27; i++) begin
      HOST.extra = i % 2;
      a = rwA[i % 9];
      rnd(v);
      if (a == ADDR_SYSCFG) v = {v[7:3], v[2] & ~v[1], v[1], 1'b0};
      if (a == ADDR_PIXHI) v = v % 8'h28;
      if (a == ADDR_LINLO) v = v | 8'h01;
      HOST.wr(a, v);
      mdl[a] = v;
      rdChk(a, mdl[a]);
    end
    HOST.extra = 0;
    settle();
    chk({8'h00, sysConfig}, {8'h00, mdl[0]}, "config");
    chk({8'h00, templateParams}, {8'h00, mdl[1]}, "params");
    chk({8'h00, opMode}, {8'h00, mdl[11]}, "mode");
    chk({8'h00, scaleCtrl}, {8'h00, mdl[13]}, "scale");
    chk(pixelsPerLine, {mdl[5], mdl[4]}, "pixels");
    chk(lineTarget, {mdl[7], mdl[6]}, "lines");
    rnd(v);
    HOST.wr(ADDR_MARKER, v);
    settle();
    chk({8'h00, markerCodeOut}, {8'h00, v}, "marker out");
    HOST.wr(ADDR_INTEN, 8'h00);
    HOST.wr(ADDR_LINLO, 8'h03);
    HOST.wr(ADDR_LINHI, 8'h00);
    HOST.wr(ADDR_OPMODE, {6'h00, MODE_ENC});
    HOST.wr(ADDR_CMDSTAT, 8'h02);
    settle();
    chk({15'h0000, engineRun}, 16'h0001, "run");
    pulse(2, 8'h00);
    for (k = 1; k <= 3; k++) pulse(0, 8'h00);
    settle();
    chk({15'h0000, engineRun}, 16'h0000, "run end");
    rdChk(ADDR_DONELO, 8'(k - 1));
    rdChk(ADDR_DONEHI, 8'h00);
    statBit(ST_OVF, 1'b1);
    statBit(ST_OVF, 1'b0);
    statBit(ST_DONE, 1'b1);
    HOST.wr(ADDR_LINLO, 8'h02);
    HOST.wr(ADDR_CMDSTAT, 8'h0A);
    settle();
    chk({15'h0000, pauseMode}, 16'h0001, "pause mode");
    repeat (2) pulse(0, 8'h00);
    settle();
    chk({15'h0000, engineRun}, 16'h0000, "paused");
    statBit(ST_PAUSED, 1'b1);
    HOST.wr(ADDR_CMDSTAT, 8'h0A);
    settle();
    chk({15'h0000, engineRun}, 16'h0001, "restart");
    HOST.wr(ADDR_CMDSTAT, 8'h00);
    settle();
    chk({15'h0000, engineRun}, 16'h0000, "stop");
    HOST.wr(ADDR_OPMODE, {6'h00, MODE_DEC});
    HOST.wr(ADDR_INTEN, 8'h04);
    HOST.wr(ADDR_CMDSTAT, 8'h02);
    rnd(v);
    pulse(1, v);
    settle();
    chk({15'h0000, engineRun}, 16'h0000, "marker pause");
    chk({15'h0000, interruptRequestOut}, 16'h0001, "irq on");
    statBit(ST_MARK, 1'b1);
    rdChk(ADDR_MARKER, v);
    settle();
    chk({15'h0000, interruptRequestOut}, 16'h0000, "irq off");
    HOST.wr(ADDR_CMDSTAT, 8'h02);
    settle();
    chk({15'h0000, engineRun}, 16'h0001, "marker restart");
    HOST.wr(ADDR_INTEN, 8'h00);
    pulse(1, v);
    settle();
    chk({15'h0000, engineRun}, 16'h0001, "no pause");
    chk({15'h0000, interruptRequestOut}, 16'h0000, "irq masked");
    HOST.wr(ADDR_CMDSTAT, 8'h00);
    @(posedge clock);
    engineEvents.wordReady <= 1'b1;
    statBit(ST_DREADY, 1'b1);
    HOST.wr(ADDR_INTEN, 8'h02);
    settle();
    chk({15'h0000, interruptRequestOut}, 16'h0001, "irq ready");
    @(posedge clock);
    engineEvents.wordReady <= 1'b0;
    settle();
    chk({15'h0000, interruptRequestOut}, 16'h0000, "irq drop");
    HOST.wr(ADDR_CMDSTAT, 8'h01);
    k = 0;
    do begin
      HOST.rd(ADDR_CMDSTAT, d, oe);
      k++;
    end while (d[ST_DONE] !== 1'b1 && k < 400);
    chk({15'h0000, d[ST_DONE]}, 16'h0001, "init done");
    if (k >= 400) results();
    HOST.wr(ADDR_CMDSTAT, 8'h04);
    for (int i = 0; i < 4; i++) begin
      rnd(v);
      q.push_back(v);
      HOST.wr(ADDR_CTXBUF, v);
    end
    q.push_back(8'h00);
    HOST.wr(ADDR_CMDSTAT, 8'h00);
    HOST.softReset();
    rdChk(ADDR_PARAM, 8'h00);
    rdChk(ADDR_LINLO, 8'h00);
    HOST.wr(ADDR_CMDSTAT, 8'h04);
    while (q.size() > 0) begin
      rdChk(ADDR_CTXBUF, q.pop_front());
    end
    HOST.wr(ADDR_CMDSTAT, 8'h00);
    settle();
    chk({15'h0000, hostDataOeN}, 16'h0001, "bus idle");
    results();
  end
endmodule

// ### verilog/bcr_host_regs.sv
// host register bank of the bi-level arithmetic coder
`timescale 1ns/1ns
module bcr_host_regs
  import bcr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // host bus
  input wire logic chipSelN,
  input wire logic [3:0] registerAddressLines,
  input wire logic writeStrobeN,
  input wire logic readStrobeN,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOeN,
  output logic interruptRequestOut,
  // engine side
  input wire bcr_engine_t engineEvents,
  output logic [7:0] sysConfig,
  output logic [7:0] templateParams,
  output logic [7:0] opMode,
  output logic [7:0] scaleCtrl,
  output logic [7:0] markerCodeOut,
  output logic [15:0] pixelsPerLine,
  output logic [15:0] lineTarget,
  output logic engineRun,
  output logic pauseMode
);
  logic [7:0] sysCfg_ff, param_ff, intEn_ff, opMode_ff, scale_ff, markOut_ff;
  logic [7:0] markIn_ff, rdData_ff;
  logic [15:0] pix_ff, lines_ff, done_ff;
  logic initCmd_ff, runCmd_ff, ctxLs_ff, pause_ff;
  logic doneSt_ff, mark_ff, ovf_ff, paused_ff, irq_ff, oeN_ff;
  logic wrPrev_ff, rdPrev_ff;
  logic [CTX_AW-1:0] ctxAddr_ff, initAddr_ff;
  logic [7:0] ctxRam [CTX_DEPTH];
  logic [7:0] ctxRd;
  bcr_state_t state_ff, nxt_state;
  logic wrPulse, rdPulse, softRst, runReq, lastLine;
  logic [5:0] statusBits;

  // strobe edges: act once per access, at strobe assertion
  assign wrPulse = !chipSelN && !writeStrobeN && !wrPrev_ff;
  assign rdPulse = !chipSelN && !readStrobeN && !rdPrev_ff;
  assign softRst = sysCfg_ff[SYS_RST];
  assign runReq = wrPulse && registerAddressLines == ADDR_CMDSTAT
    && hostDataIn[CMD_RUN];
  assign lastLine = engineEvents.lineDone && (done_ff + 16'h0001 >= lines_ff);
  assign ctxRd = ctxRam[ctxAddr_ff];

  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrPrev_ff <= 1'b0;
      rdPrev_ff <= 1'b0;
    end else begin
      wrPrev_ff <= !chipSelN && !writeStrobeN;
      rdPrev_ff <= !chipSelN && !readStrobeN;
    end
  end

  // system configuration survives soft reset so the bit can be cleared
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sysCfg_ff <= RST_BYTE;
    end else if (wrPulse && registerAddressLines == ADDR_SYSCFG) begin
      sysCfg_ff <= hostDataIn;
    end
  end

  // plain configuration registers
  always_ff @(posedge clock) begin
    if (!rstn || softRst) begin
      param_ff <= RST_BYTE;
      intEn_ff <= RST_BYTE;
      opMode_ff <= RST_BYTE;
      scale_ff <= RST_BYTE;
      markOut_ff <= MARK_SDNORM;
      pix_ff <= RST_WORD;
      lines_ff <= RST_WORD;
    end else if (wrPulse) begin
      unique case (registerAddressLines)
        ADDR_PARAM: param_ff <= hostDataIn;
        ADDR_INTEN: intEn_ff <= hostDataIn;
        ADDR_PIXLO: pix_ff[7:0] <= hostDataIn;
        ADDR_PIXHI: pix_ff[15:8] <= hostDataIn;
        ADDR_LINLO: lines_ff[7:0] <= hostDataIn;
        ADDR_LINHI: lines_ff[15:8] <= hostDataIn;
        ADDR_OPMODE: opMode_ff <= hostDataIn;
        ADDR_MARKER: markOut_ff <= hostDataIn;
        ADDR_SCALE: scale_ff <= hostDataIn;
        default: ;
      endcase
    end
  end

  // command bits
  always_ff @(posedge clock) begin
    if (!rstn || softRst) begin
      initCmd_ff <= 1'b0;
      runCmd_ff <= 1'b0;
      ctxLs_ff <= 1'b0;
      pause_ff <= 1'b0;
    end else if (wrPulse && registerAddressLines == ADDR_CMDSTAT) begin
      initCmd_ff <= hostDataIn[CMD_INIT];
      runCmd_ff <= hostDataIn[CMD_RUN];
      ctxLs_ff <= hostDataIn[CMD_CTXLS];
      pause_ff <= hostDataIn[CMD_PAUSE];
    end else begin
      if (state_ff == ST_INIT && initAddr_ff == CTX_LAST) begin
        initCmd_ff <= 1'b0;
      end
      if (state_ff == ST_RUN && lastLine && !pause_ff) begin
        runCmd_ff <= 1'b0;
      end
    end
  end

  // sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (initCmd_ff) begin
          nxt_state = ST_INIT;
        end else if (runCmd_ff) begin
          nxt_state = ST_RUN;
        end
      end
      ST_INIT: begin
        if (initAddr_ff == CTX_LAST) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RUN: begin
        if (!runCmd_ff) begin
          nxt_state = ST_IDLE;
        end else if (lastLine && pause_ff) begin
          nxt_state = ST_HOLD;
        end else if (engineEvents.markerSeen && intEn_ff[ST_MARK]
            && opMode_ff[1:0] == MODE_DEC) begin
          nxt_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (runReq) begin
          nxt_state = ST_RUN;
        end else if (!runCmd_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn || softRst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || softRst) begin
      initAddr_ff <= '0;
    end else if (state_ff == ST_INIT) begin
      initAddr_ff <= initAddr_ff + 1'b1;
    end else begin
      initAddr_ff <= '0;
    end
  end

  // context table RAM, not touched by soft reset
  always_ff @(posedge clock) begin
    if (state_ff == ST_INIT) begin
      ctxRam[initAddr_ff] <= RST_BYTE;
    end else if (wrPulse && registerAddressLines == ADDR_CTXBUF
        && ctxLs_ff) begin
      ctxRam[ctxAddr_ff] <= hostDataIn;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || softRst || !ctxLs_ff) begin
      ctxAddr_ff <= '0;
    end else if ((wrPulse || rdPulse)
        && registerAddressLines == ADDR_CTXBUF) begin
      ctxAddr_ff <= ctxAddr_ff + 1'b1;
    end
  end

  // line counter; restarts when a fresh run begins from idle
  always_ff @(posedge clock) begin
    if (!rstn || softRst) begin
      done_ff <= RST_WORD;
    end else if (state_ff == ST_IDLE && nxt_state == ST_RUN) begin
      done_ff <= RST_WORD;
    end else if (state_ff == ST_HOLD && runReq && !mark_ff) begin
      done_ff <= RST_WORD;
    end else if (state_ff == ST_RUN && engineEvents.lineDone
        && done_ff != 16'hFFFF) begin
      done_ff <= done_ff + 16'h0001;
    end
  end

  // status flags: event set wins over clearing
  always_ff @(posedge clock) begin
    if (!rstn || softRst) begin
      doneSt_ff <= 1'b0;
      mark_ff <= 1'b0;
      ovf_ff <= 1'b0;
      paused_ff <= 1'b0;
      markIn_ff <= RST_BYTE;
    end else begin
      if ((state_ff == ST_RUN || state_ff == ST_INIT)
          && nxt_state != state_ff) begin
        doneSt_ff <= 1'b1;
      end else if (runReq || (wrPulse && registerAddressLines == ADDR_CMDSTAT
          && hostDataIn[CMD_INIT])) begin
        doneSt_ff <= 1'b0;
      end
      if (engineEvents.markerSeen && opMode_ff[1:0] == MODE_DEC) begin
        mark_ff <= 1'b1;
        markIn_ff <= engineEvents.markerCode;
      end else if (rdPulse && registerAddressLines == ADDR_MARKER) begin
        mark_ff <= 1'b0;
      end
      if (engineEvents.counterOverflow) begin
        ovf_ff <= 1'b1;
      end else if (rdPulse && registerAddressLines == ADDR_CMDSTAT) begin
        ovf_ff <= 1'b0;
      end
      paused_ff <= (nxt_state == ST_HOLD);
    end
  end

  assign statusBits = {paused_ff, ovf_ff, 1'b0, mark_ff,
    engineEvents.wordReady, doneSt_ff};

  // interrupt: any enabled status condition
  always_ff @(posedge clock) begin
    if (!rstn || softRst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(statusBits & intEn_ff[5:0]);
    end
  end

  // read path
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdData_ff <= RST_BYTE;
      oeN_ff <= 1'b1;
    end else begin
      oeN_ff <= chipSelN || readStrobeN;
      // frozen for the rest of a read: clear-on-read and address step
      // land on its first edge and must not change what the host sees
      if (!rdPrev_ff) begin
        unique case (registerAddressLines)
          ADDR_SYSCFG: rdData_ff <= sysCfg_ff;
          ADDR_PARAM: rdData_ff <= param_ff;
          ADDR_CMDSTAT: rdData_ff <= {2'b00, statusBits[5:4], irq_ff,
            statusBits[2:0]};
          ADDR_INTEN: rdData_ff <= intEn_ff;
          ADDR_PIXLO: rdData_ff <= pix_ff[7:0];
          ADDR_PIXHI: rdData_ff <= pix_ff[15:8];
          ADDR_LINLO: rdData_ff <= lines_ff[7:0];
          ADDR_LINHI: rdData_ff <= lines_ff[15:8];
          ADDR_DONELO: rdData_ff <= done_ff[7:0];
          ADDR_DONEHI: rdData_ff <= done_ff[15:8];
          ADDR_CTXBUF: rdData_ff <= ctxRd;
          ADDR_OPMODE: rdData_ff <= opMode_ff;
          ADDR_MARKER: rdData_ff <= markIn_ff;
          ADDR_SCALE: rdData_ff <= scale_ff;
          default: rdData_ff <= RST_BYTE;
        endcase
      end
    end
  end

  // registered engine-facing copies
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sysConfig <= RST_BYTE;
      templateParams <= RST_BYTE;
      opMode <= RST_BYTE;
      scaleCtrl <= RST_BYTE;
      markerCodeOut <= RST_BYTE;
      pixelsPerLine <= RST_WORD;
      lineTarget <= RST_WORD;
      engineRun <= 1'b0;
      pauseMode <= 1'b0;
    end else begin
      sysConfig <= sysCfg_ff;
      templateParams <= param_ff;
      opMode <= opMode_ff;
      scaleCtrl <= scale_ff;
      markerCodeOut <= markOut_ff;
      pixelsPerLine <= pix_ff;
      lineTarget <= lines_ff;
      engineRun <= (nxt_state == ST_RUN);
      pauseMode <= pause_ff;
    end
  end

  assign hostDataOut = rdData_ff;
  assign hostDataOeN = oeN_ff;
  assign interruptRequestOut = irq_ff;

  a_init_self_clear: assert property (@(posedge clock) disable iff (!rstn)
    state_ff == ST_INIT && initAddr_ff == CTX_LAST && !wrPulse
    |=> !initCmd_ff)
    else $error("init command did not clear");
  a_run_term_clear: assert property (@(posedge clock) disable iff (!rstn)
    state_ff == ST_RUN && lastLine && !pause_ff && !wrPulse && !softRst
    |=> !runCmd_ff)
    else $error("run bit did not clear at termination");
  a_irq_gating: assert property (@(posedge clock) disable iff (!rstn)
    !softRst && ((statusBits & intEn_ff[5:0]) == 6'h00)
    |=> !interruptRequestOut)
    else $error("interrupt without enabled cause");
  a_ctx_addr_step: assert property (@(posedge clock) disable iff (!rstn)
    ctxLs_ff && !softRst && rdPulse && registerAddressLines == ADDR_CTXBUF
    |=> ctxAddr_ff == $past(ctxAddr_ff) + 1'b1)
    else $error("context address did not advance");
  a_soft_reset_clr: assert property (@(posedge clock) disable iff (!rstn)
    softRst |=> state_ff == ST_IDLE && intEn_ff == RST_BYTE)
    else $error("soft reset did not clear");
  a_marker_pause: assert property (@(posedge clock) disable iff (!rstn)
    state_ff == ST_RUN && runCmd_ff && !softRst && engineEvents.markerSeen
    && intEn_ff[ST_MARK] && opMode_ff[1:0] == MODE_DEC
    |=> state_ff == ST_HOLD && paused_ff)
    else $error("no pause on marker");
  a_read_hold: assert property (@(posedge clock) disable iff (!rstn)
    rdPrev_ff |=> $stable(hostDataOut))
    else $error("read data moved during access");
  a_line_count: assert property (@(posedge clock) disable iff (!rstn)
    state_ff == ST_RUN && nxt_state == ST_RUN && !softRst
    && engineEvents.lineDone && done_ff != 16'hFFFF
    |=> done_ff == $past(done_ff) + 16'h0001)
    else $error("line count did not advance");
  a_status_read: assert property (@(posedge clock) disable iff (!rstn)
    registerAddressLines == ADDR_CMDSTAT ##1
    registerAddressLines == ADDR_CMDSTAT
    |-> hostDataOut[7:6] == 2'b00)
    else $error("status read upper bits not zero");
  c_init_done: cover property (@(posedge clock) state_ff == ST_INIT
    ##1 state_ff == ST_IDLE);
  c_run_term: cover property (@(posedge clock) state_ff == ST_RUN
    && lastLine && !pause_ff);
  c_pause_resume: cover property (@(posedge clock) state_ff == ST_HOLD
    ##[1:20] state_ff == ST_RUN);
endmodule
